// File: logic/fesd_defs.vh
// Constants for the erase, suspend and power-down command sequencer
`ifndef FESD_DEFS_VH
`define FESD_DEFS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define FESD_OP_WRSR 8'h01
`define FESD_OP_PP 8'h02
`define FESD_OP_WRDI 8'h04
`define FESD_OP_RDSR 8'h05
`define FESD_OP_WREN 8'h06
`define FESD_OP_SE 8'h20
`define FESD_OP_QPP 8'h32
`define FESD_OP_PSR 8'h42
`define FESD_OP_ESR 8'h44
`define FESD_OP_BE32 8'h52
`define FESD_OP_CE_A 8'h60
`define FESD_OP_SUSP 8'h75
`define FESD_OP_RESM 8'h7A
`define FESD_OP_RELPD 8'hAB
`define FESD_OP_PDOWN 8'hB9
`define FESD_OP_CE_B 8'hC7
`define FESD_OP_BE64 8'hD8
`define FESD_OP_BE64_4B 8'hDC

// ----------------------------------------------------------------------
// Operation kinds and latency phases
// ----------------------------------------------------------------------
`define FESD_K_SECT 3'h0
`define FESD_K_BLK32 3'h1
`define FESD_K_BLK64 3'h2
`define FESD_K_CHIP 3'h3
`define FESD_K_PROG 3'h4
`define FESD_PH_NONE 3'h0
`define FESD_PH_SUS 3'h1
`define FESD_PH_RES 3'h2
`define FESD_PH_PDE 3'h3
`define FESD_PH_PDX 3'h4

// ----------------------------------------------------------------------
// Framing, status byte layout and timing
// ----------------------------------------------------------------------
`define FESD_BIT_LAST 3'h7
`define FESD_BYTE_MAX 3'h7
`define FESD_ADDR3 3'h3
`define FESD_ADDR4 3'h4
`define FESD_ID_LAST_DUMMY 3'h3
`define FESD_ST_BUSY 0
`define FESD_ST_WEL 1
`define FESD_ST_PAUSED 7
`define FESD_CLK_PERIOD_NS 20
`define FESD_RESUME_NS 200
// One cycle less: the busy register lags the timer pulse by one clock
`define FESD_RESUME_CYC (`FESD_RESUME_NS / `FESD_CLK_PERIOD_NS - 1)

`endif

// File: logic/fesd_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module fesd_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire pin_i,
    output reg level_o
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // Level moves only once stages two and three agree
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule // fesd_sync

// File: logic/fesd_tmr.v
// Loadable down-counter that pulses once when a latency expires
`timescale 1ns/10ps
module fesd_tmr (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire load_i,
    input wire [15:0] count_i,
    output reg done_o
);
    reg [15:0] cnt_reg;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cnt_reg <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt_reg <= count_i;
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg - 16'h0001;
                done_o <= (cnt_reg == 16'h0001);
            end
        end
    end
endmodule // fesd_tmr

// File: logic/fesd_seq.v
// Erase, suspend/resume and power-down command sequencer (serial side)
`timescale 1ns/10ps
`include "fesd_defs.vh"
module fesd_seq #(
    parameter [7:0] DEV_ID = 8'h5A, // Arbitrary value
    parameter [31:0] SECT_CYC = 32'd20000,
    parameter [31:0] BLK32_CYC = 32'd40000,
    parameter [31:0] BLK64_CYC = 32'd60000,
    parameter [31:0] CHIP_CYC = 32'd200000,
    parameter [31:0] PROG_CYC = 32'd10000,
    parameter [15:0] TSUS_CYC = 16'd1000,
    parameter [15:0] TDP_CYC = 16'd150,
    parameter [15:0] TREST_CYC = 16'd150
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire mosi_i,
    input wire addr4_mode_i,
    input wire addr_protected_i,
    input wire any_protected_i,
    output reg miso_o,
    output reg miso_oe_o,
    output reg busy_o,
    output reg write_enable_latch_o,
    output reg paused_flag_o,
    output reg power_down_o,
    output reg [31:0] cand_addr_o,
    output reg op_start_o,
    output reg [2:0] op_kind_o,
    output reg [31:0] op_addr_o,
    output reg op_done_o,
    output reg sr_write_o,
    output reg [7:0] sr_data_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    wire cs_n_lvl;
    wire sclk_lvl;
    wire mosi_lvl;
    reg cs_d_reg;
    reg sclk_d_reg;

    fesd_sync #(.RST_VAL(1'b1)) u_cs (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(cs_n_i),
        .level_o(cs_n_lvl)
    );
    fesd_sync #(.RST_VAL(1'b0)) u_sclk (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(sclk_i),
        .level_o(sclk_lvl)
    );
    fesd_sync #(.RST_VAL(1'b0)) u_mosi (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(mosi_i),
        .level_o(mosi_lvl)
    );

    wire sclk_rise = sclk_lvl & ~sclk_d_reg & ~cs_n_lvl;
    wire sclk_fall = ~sclk_lvl & sclk_d_reg & ~cs_n_lvl;
    wire cs_rise = cs_n_lvl & ~cs_d_reg;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    reg [2:0] bit_cnt_reg;
    reg [2:0] byte_cnt_reg;
    reg [6:0] rx_reg;
    reg [7:0] opc_reg;
    reg [7:0] tx_reg;
    reg tx_en_reg;
    reg [31:0] op_cnt_reg;
    reg [31:0] saved_cnt_reg;
    reg [2:0] saved_kind_reg;
    reg [2:0] phase_reg;

    wire [7:0] rx_byte = {rx_reg, mosi_lvl};
    wire byte_done = sclk_rise & (bit_cnt_reg == `FESD_BIT_LAST);
    wire [7:0] status_byte = {paused_flag_o, 5'h00,
                              write_enable_latch_o, busy_o};

    // DCh ignores the address-mode setting
    wire [2:0] addr_bytes = (opc_reg == `FESD_OP_BE64_4B) ? `FESD_ADDR4 :
        (addr4_mode_i ? `FESD_ADDR4 : `FESD_ADDR3);
    wire [2:0] addr_last = addr_bytes + 3'h1;
    wire on_bound = (bit_cnt_reg == 3'h0);
    wire opc_end = on_bound & (byte_cnt_reg == 3'h1);
    wire addr_end = on_bound & (byte_cnt_reg == addr_last);
    wire data_end = on_bound & (byte_cnt_reg > addr_last);

    // ------------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------------
    wire is_ce = (opc_reg == `FESD_OP_CE_B) |
                 (opc_reg == `FESD_OP_CE_A);
    wire is_blk_erase = (opc_reg == `FESD_OP_SE) |
                        (opc_reg == `FESD_OP_BE32) |
                        (opc_reg == `FESD_OP_BE64) |
                        (opc_reg == `FESD_OP_BE64_4B);
    wire is_prog = (opc_reg == `FESD_OP_PP) | (opc_reg == `FESD_OP_QPP);
    wire susp_erase = paused_flag_o & (saved_kind_reg != `FESD_K_PROG);
    wire susp_prog = paused_flag_o & (saved_kind_reg == `FESD_K_PROG);
    wire erase_barred = susp_erase & (is_ce | is_blk_erase |
                        (opc_reg == `FESD_OP_ESR));
    wire prog_barred = susp_prog & (is_prog |
                       (opc_reg == `FESD_OP_PSR));
    wire pd_block = power_down_o | (phase_reg == `FESD_PH_PDE) |
                    (phase_reg == `FESD_PH_PDX);
    wire ph_idle = (phase_reg == `FESD_PH_NONE);
    wire cmd_ok = cs_rise & ~pd_block;
    wire can_run = cmd_ok & ~busy_o & write_enable_latch_o;

    wire start_blk = can_run & is_blk_erase & addr_end &
                     ~erase_barred & ~addr_protected_i;
    wire start_chip = can_run & is_ce & opc_end & ~erase_barred &
                      ~any_protected_i;
    wire start_prog = can_run & is_prog & data_end & ~prog_barred &
                      ~addr_protected_i;
    wire start_any = start_blk | start_chip | start_prog;
    wire sus_ok = cmd_ok & (opc_reg == `FESD_OP_SUSP) & opc_end &
                  ~paused_flag_o & busy_o & ph_idle &
                  (op_kind_o != `FESD_K_CHIP);
    wire res_ok = cmd_ok & (opc_reg == `FESD_OP_RESM) & opc_end &
                  paused_flag_o & ~busy_o & ph_idle;
    wire pd_enter = cmd_ok & (opc_reg == `FESD_OP_PDOWN) & opc_end &
                    ~busy_o & ph_idle;
    wire pd_exit = cs_rise & power_down_o & ph_idle &
                   (opc_reg == `FESD_OP_RELPD) & opc_end;
    wire wren_ok = cmd_ok & ~busy_o & opc_end &
                   (opc_reg == `FESD_OP_WREN);
    wire wrdi_ok = cmd_ok & ~busy_o & opc_end &
                   (opc_reg == `FESD_OP_WRDI);
    wire srw_ok = can_run & ~paused_flag_o & on_bound &
                  (byte_cnt_reg == 3'h2) &
                  (opc_reg == `FESD_OP_WRSR);

    reg [2:0] new_kind;
    reg [31:0] new_dur;
    always @* begin
        new_kind = `FESD_K_PROG;
        new_dur = PROG_CYC;
        if (start_chip) begin
            new_kind = `FESD_K_CHIP;
            new_dur = CHIP_CYC;
        end else if (start_blk) begin
            case (opc_reg)
                `FESD_OP_SE: begin
                    new_kind = `FESD_K_SECT;
                    new_dur = SECT_CYC;
                end
                `FESD_OP_BE32: begin
                    new_kind = `FESD_K_BLK32;
                    new_dur = BLK32_CYC;
                end
                default: begin
                    // Same kind and duration as D8h
                    new_kind = `FESD_K_BLK64;
                    new_dur = BLK64_CYC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Latency timer for suspend, resume and power transitions
    // ------------------------------------------------------------------
    wire tmr_load = sus_ok | res_ok | pd_enter | pd_exit;
    wire tmr_done;
    localparam [15:0] RESUME_CYC = `FESD_RESUME_CYC;
    reg [15:0] tmr_count;
    always @* begin
        if (sus_ok) begin
            tmr_count = TSUS_CYC;
        end else if (res_ok) begin
            tmr_count = RESUME_CYC;
        end else if (pd_enter) begin
            tmr_count = TDP_CYC;
        end else begin
            tmr_count = TREST_CYC;
        end
    end

    fesd_tmr u_tmr (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // ------------------------------------------------------------------
    // Serial shifting
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cs_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            rx_reg <= 7'h00;
            opc_reg <= 8'h00;
            cand_addr_o <= 32'h00000000;
            tx_reg <= 8'h00;
            tx_en_reg <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            cs_d_reg <= cs_n_lvl;
            sclk_d_reg <= sclk_lvl;
            if (cs_n_lvl) begin
                bit_cnt_reg <= 3'h0;
                byte_cnt_reg <= 3'h0;
                tx_en_reg <= 1'b0;
                miso_oe_o <= 1'b0;
            end else begin
                miso_oe_o <= tx_en_reg;
                if (sclk_rise) begin
                    // MSB first on rising edges
                    rx_reg <= rx_byte[6:0];
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (byte_cnt_reg != 3'h0 &&
                        byte_cnt_reg <= addr_bytes) begin
                        cand_addr_o <= {cand_addr_o[30:0], mosi_lvl};
                    end
                end
                if (byte_done) begin
                    if (byte_cnt_reg != `FESD_BYTE_MAX) begin
                        byte_cnt_reg <= byte_cnt_reg + 3'h1;
                    end
                    if (byte_cnt_reg == 3'h0) begin
                        opc_reg <= rx_byte;
                    end
                    if (!pd_block && byte_cnt_reg == 3'h0 &&
                        rx_byte == `FESD_OP_RDSR) begin
                        tx_reg <= status_byte;
                        tx_en_reg <= 1'b1;
                    end
                    if (!pd_block && opc_reg == `FESD_OP_RELPD &&
                        byte_cnt_reg == `FESD_ID_LAST_DUMMY) begin
                        tx_reg <= DEV_ID;
                        tx_en_reg <= 1'b1;
                    end
                end
                // Rotating keeps repeating the byte until select rises
                if (sclk_fall && tx_en_reg) begin
                    miso_o <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], tx_reg[7]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Operation control
    // ------------------------------------------------------------------
    // Reset stands for power-up: not paused, not powered down
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
            write_enable_latch_o <= 1'b0;
            paused_flag_o <= 1'b0;
            power_down_o <= 1'b0;
            op_start_o <= 1'b0;
            op_kind_o <= `FESD_K_SECT;
            op_addr_o <= 32'h00000000;
            op_done_o <= 1'b0;
            sr_write_o <= 1'b0;
            sr_data_o <= 8'h00;
            op_cnt_reg <= 32'h00000000;
            saved_cnt_reg <= 32'h00000000;
            saved_kind_reg <= `FESD_K_SECT;
            phase_reg <= `FESD_PH_NONE;
        end else begin
            op_start_o <= 1'b0;
            op_done_o <= 1'b0;
            sr_write_o <= 1'b0;
            if (wren_ok) begin
                write_enable_latch_o <= 1'b1;
            end
            if (wrdi_ok) begin
                write_enable_latch_o <= 1'b0;
            end
            if (srw_ok) begin
                sr_write_o <= 1'b1;
                // Data byte rode in through the address shifter
                sr_data_o <= cand_addr_o[7:0];
            end
            // Self-timed run; frozen only while suspend settles
            if (start_any) begin
                busy_o <= 1'b1;
                op_cnt_reg <= new_dur;
                op_kind_o <= new_kind;
                op_addr_o <= cand_addr_o;
                op_start_o <= 1'b1;
            end else if (busy_o && phase_reg != `FESD_PH_SUS) begin
                if (op_cnt_reg <= 32'h00000001) begin
                    busy_o <= 1'b0;
                    write_enable_latch_o <= 1'b0;
                    op_done_o <= 1'b1;
                end else begin
                    op_cnt_reg <= op_cnt_reg - 32'h00000001;
                end
            end
            if (sus_ok) begin
                paused_flag_o <= 1'b1;
                phase_reg <= `FESD_PH_SUS;
            end
            if (res_ok) begin
                paused_flag_o <= 1'b0;
                phase_reg <= `FESD_PH_RES;
            end
            if (pd_enter) begin
                phase_reg <= `FESD_PH_PDE;
            end
            if (pd_exit) begin
                phase_reg <= `FESD_PH_PDX;
            end
            if (tmr_done) begin
                phase_reg <= `FESD_PH_NONE;
                case (phase_reg)
                    `FESD_PH_SUS: begin
                        saved_cnt_reg <= op_cnt_reg;
                        saved_kind_reg <= op_kind_o;
                        busy_o <= 1'b0;
                    end
                    `FESD_PH_RES: begin
                        busy_o <= 1'b1;
                        op_cnt_reg <= saved_cnt_reg;
                        op_kind_o <= saved_kind_reg;
                    end
                    `FESD_PH_PDE: begin
                        power_down_o <= 1'b1;
                    end
                    `FESD_PH_PDX: begin
                        power_down_o <= 1'b0;
                    end
                    default: power_down_o <= power_down_o;
                endcase
            end
        end
    end
endmodule // fesd_seq

// File: testbench/fesd_seq_sva.sv
// Port-level assertions for the erase, suspend and power-down sequencer
`timescale 1ns/10ps
module fesd_seq_sva #(
    parameter [15:0] TSUS_CYC = 16'h3E8
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire any_protected_i,
    input wire miso_oe_o,
    input wire busy_o,
    input wire write_enable_latch_o,
    input wire paused_flag_o,
    input wire power_down_o,
    input wire op_start_o,
    input wire [2:0] op_kind_o,
    input wire op_done_o,
    input wire sr_write_o
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int SUS_MAX = TSUS_CYC + 4;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_start_sets_busy: assert property (op_start_o |-> busy_o)
        else $error("busy low at operation start");
    a_chip_needs_wel: assert property (
        op_start_o && op_kind_o == 3'h3 |-> $past(write_enable_latch_o))
        else $error("chip erase started without write enable");
    a_chip_unprotected: assert property (
        op_start_o && op_kind_o == 3'h3 |-> !$past(any_protected_i))
        else $error("chip erase started while protected");
    a_done_clears_flags: assert property (
        op_done_o |-> ##[0:1] (!write_enable_latch_o && !busy_o))
        else $error("flags not cleared after completion");
    a_wake_normal: assert property (
        $rose(resetn_i) |-> !paused_flag_o && !power_down_o)
        else $error("paused or powered down after reset");
    a_pause_needs_busy: assert property (
        $rose(paused_flag_o) |-> $past(busy_o))
        else $error("suspend taken while idle");
    a_pause_latency: assert property (
        $rose(paused_flag_o) |-> ##[1:SUS_MAX] !busy_o)
        else $error("busy did not fall after suspend");
    a_resume_idle: assert property (
        $fell(paused_flag_o) |-> !$past(busy_o))
        else $error("resume taken while busy");
    a_resume_busy: assert property (
        $fell(paused_flag_o) |-> ##[1:10] busy_o)
        else $error("busy not raised after resume");
    a_pd_no_ops: assert property (
        power_down_o |-> !op_start_o && !sr_write_o)
        else $error("command run in power-down");
    a_pd_quiet: assert property (
        power_down_o && $past(power_down_o) |-> !miso_oe_o)
        else $error("output driven in power-down");
endmodule // fesd_seq_sva

bind fesd_seq fesd_seq_sva #(.TSUS_CYC(TSUS_CYC)) i_sva (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .any_protected_i(any_protected_i), .miso_oe_o(miso_oe_o),
    .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
    .paused_flag_o(paused_flag_o), .power_down_o(power_down_o),
    .op_start_o(op_start_o), .op_kind_o(op_kind_o),
    .op_done_o(op_done_o), .sr_write_o(sr_write_o)
);

// File: testbench/fesd_host.sv
// Behavioural serial host that frames instructions for the sequencer
`timescale 1ns/10ps
module fesd_host (
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // Bits leave tx from the top; clock stands low outside frames
    task automatic frame(input logic [63:0] tx, input int nbits,
                         output logic [7:0] rx);
        int i;
        rx = 8'h00;
        #37 cs_n_o = 1'b0;
        for (i = 0; i < nbits; i++) begin
            mosi_o = tx[63 - i];
            #80 sclk_o = 1'b1;
            // Sample late in the high phase, output lags the fall
            #78 rx = {rx[6:0], miso_i};
            #2 sclk_o = 1'b0;
        end
        #80 mosi_o = ~mosi_o;
        cs_n_o = 1'b1;
        #600;
    endtask
endmodule // fesd_host

// File: testbench/fesd_seq_test.sv
// Self-checking bench for the erase, suspend and power-down sequencer
`timescale 1ns/10ps
module fesd_seq_test;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    localparam [7:0] ID = 8'h3C; // Arbitrary value
    localparam [31:0] T_BLK = 32'h64;
    localparam [15:0] T_LAT = 16'h14;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic addr4_mode_i = 1'b0;
    logic any_protected_i = 1'b0;
    logic addr_protected_i = 1'b0;
    wire cs_n, sclk, mosi, miso, miso_oe, busy, write_enable_latch, paused, pd;
    wire op_start, op_done, sr_write;
    wire [31:0] cand_addr, op_addr;
    wire [2:0] op_kind;
    wire [7:0] sr_data;
    // Released line shows the inverse, never a stale bit
    wire miso_line = miso_oe ? miso : ~miso;
    logic [31:0] starts = 0, oe_seen = 0, cycles = 0, addr_seen = 0;
    logic [2:0] kind_seen = 3'h0;
    logic [7:0] rx;
    int bad_count = 0;
    int checks_done = 0;

    initial forever #10 ref_clk_i = ~ref_clk_i;
    fesd_host i_host (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
        .miso_i(miso_line));
    fesd_seq #(.DEV_ID(ID), .SECT_CYC(32'h190), .BLK32_CYC(T_BLK),
        .BLK64_CYC(T_BLK), .CHIP_CYC(32'h258), .PROG_CYC(32'h12C),
        .TSUS_CYC(T_LAT), .TDP_CYC(T_LAT), .TREST_CYC(T_LAT)) i_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .mosi_i(mosi), .addr4_mode_i(addr4_mode_i),
        .addr_protected_i(addr_protected_i),
        .any_protected_i(any_protected_i),
        .miso_o(miso), .miso_oe_o(miso_oe), .busy_o(busy),
        .write_enable_latch_o(write_enable_latch), .paused_flag_o(paused),
        .power_down_o(pd), .cand_addr_o(cand_addr), .op_start_o(op_start),
        .op_kind_o(op_kind), .op_addr_o(op_addr), .op_done_o(op_done),
        .sr_write_o(sr_write), .sr_data_o(sr_data));

    // Refused commands show only as missing start or write pulses
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (op_start === 1'b1 || sr_write === 1'b1) starts <= starts + 1;
        if (op_start === 1'b1) begin
            kind_seen <= op_kind;
            addr_seen <= op_addr;
        end
        if (miso_oe === 1'b1) oe_seen <= oe_seen + 1;
        if (cycles == 32'd40000) begin
            bad_count++;
            end_of_test;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic op8(logic [7:0] b);
        i_host.frame({b, 56'h0}, 8, rx);
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge ref_clk_i);
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic refuse(logic [7:0] op, int nb);
        logic [31:0] s;
        s = starts;
        op8(8'h06);
        i_host.frame({op, 24'h002000, 32'h0}, nb, rx);
        chk("refused start", s, starts);
    endtask
    task automatic pause_op(logic [63:0] tx, int nb, logic [2:0] k);
        op8(8'h06);
        i_host.frame(tx, nb, rx);
        chk("kind", k, kind_seen);
        op8(8'h75);
        chk("paused", 1, paused);
        chk("busy", 0, busy);
    endtask
    task automatic resume_op;
        op8(8'h75);
        chk("paused kept", 1, paused);
        op8(8'h7A);
        chk("paused", 0, paused);
        chk("busy", 1, busy);
        wait_idle;
        chk("wel", 0, write_enable_latch);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("paused", 0, paused);
        chk("power down", 0, pd);
        i_host.frame({8'h05, 56'h0}, 16, rx);
        chk("status", 8'h00, rx);
        op8(8'h06);
        i_host.frame({8'h01, 8'hA5, 48'h0}, 16, rx);
        chk("status write", 8'hA5, sr_data);
        $display("test reset done");
    endtask
    task automatic t_chip;
        logic [7:0] ops [2] = '{8'hC7, 8'h60};
        logic [31:0] s;
        foreach (ops[i]) begin
            op8(8'h04);
            s = starts;
            op8(ops[i]);
            chk("no wel start", s, starts);
            op8(8'h06);
            i_host.frame({ops[i], 56'h0}, 7, rx);
            chk("short frame start", s, starts);
            @(posedge ref_clk_i) any_protected_i <= 1'b1;
            op8(8'h06);
            op8(ops[i]);
            chk("protected start", s, starts);
            @(posedge ref_clk_i) any_protected_i <= 1'b0;
            op8(8'h06);
            op8(ops[i]);
            chk("chip start", s + 1, starts);
            chk("chip kind", 3'h3, kind_seen);
            i_host.frame({8'h05, 56'h0}, 16, rx);
            chk("busy status", 1, rx[0]);
            op8(8'h75);
            chk("paused", 0, paused);
            wait_idle;
            chk("wel", 0, write_enable_latch);
        end
        $display("test chip erase done");
    endtask
    task automatic t_block;
        logic [31:0] s;
        op8(8'h06);
        s = starts;
        i_host.frame({8'hDC, 24'h123456, 32'h0}, 32, rx);
        chk("short start", s, starts);
        @(posedge ref_clk_i) addr_protected_i <= 1'b1;
        refuse(8'hDC, 40);
        @(posedge ref_clk_i) addr_protected_i <= 1'b0;
        op8(8'h06);
        i_host.frame({8'hDC, 32'h89ABCDEF, 24'h0}, 40, rx);
        chk("wide kind", 3'h2, kind_seen);
        chk("wide address", 32'h89ABCDEF, addr_seen);
        chk("shifted address", 32'h89ABCDEF, cand_addr);
        wait_idle;
        @(posedge ref_clk_i) addr4_mode_i <= 1'b1;
        op8(8'h06);
        i_host.frame({8'hD8, 32'h01234567, 24'h0}, 40, rx);
        chk("plain kind", 3'h2, kind_seen);
        chk("plain address", 32'h01234567, addr_seen);
        wait_idle;
        @(posedge ref_clk_i) addr4_mode_i <= 1'b0;
        $display("test block erase done");
    endtask
    task automatic t_erase_sus;
        logic [7:0] ops [7] = '{8'h01, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60,
            8'h44};
        int nb [7] = '{16, 32, 32, 32, 8, 8, 32};
        pause_op({8'h20, 24'h001000, 32'h0}, 32, 3'h0);
        foreach (ops[i]) refuse(ops[i], nb[i]);
        resume_op;
        $display("test erase suspend done");
    endtask
    task automatic t_prog_sus;
        logic [7:0] ops [4] = '{8'h01, 8'h02, 8'h32, 8'h42};
        int nb [4] = '{16, 40, 40, 40};
        pause_op({8'h02, 24'h000100, 8'hA5, 24'h0}, 40, 3'h4);
        foreach (ops[i]) refuse(ops[i], nb[i]);
        resume_op;
        $display("test program suspend done");
    endtask
    task automatic t_power;
        logic [31:0] s;
        i_host.frame({8'hB9, 56'h0}, 9, rx);
        chk("late select", 0, pd);
        op8(8'hB9);
        chk("power down", 1, pd);
        s = oe_seen;
        i_host.frame({8'h05, 56'h0}, 16, rx);
        chk("status driven", s, oe_seen);
        op8(8'h06);
        chk("wel", 0, write_enable_latch);
        op8(8'hAB);
        chk("released", 0, pd);
        i_host.frame({8'hAB, 24'h0, 32'h0}, 48, rx);
        chk("device id", ID, rx);
        $display("test power-down done");
    endtask
    task automatic t_power_loss;
        pause_op({8'h20, 24'h004000, 32'h0}, 32, 3'h0);
        @(posedge ref_clk_i) resetn_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        chk("paused", 0, paused);
        op8(8'h7A);
        chk("busy", 0, busy);
        $display("test power loss done");
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        t_reset;
        t_chip;
        t_block;
        t_erase_sus;
        t_prog_sus;
        t_power;
        t_power_loss;
        end_of_test;
    end
endmodule // fesd_seq_test
